// >>> camera_io_cfg.svh
// Constants for the camera board trigger and output control block
`ifndef CAMERA_IO_CFG_SVH
`define CAMERA_IO_CFG_SVH
`define CIO_I2C_ADDR 7'h20
`define CIO_BIT_POWER 0
`define CIO_BIT_RESET 1
`define CIO_BIT_LEVEL 2
`define CIO_BIT_DRIVE 3
`define CIO_BIT_SOURCE 4
`define CIO_BIT_TRIG_INV 5
`define CIO_BIT_TRIG_SRC 6
`define CIO_CTRL_RESET 8'h00
`define CIO_BIT_CYCLES 8
`endif

// >>> camera_io_pkg.sv
// Types for the camera board trigger and output control block
package camera_io_pkg;
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_DATA, I2C_DATA_ACK, I2C_READ, I2C_READ_ACK, I2C_SKIP
  } i2c_state_e;
  typedef logic [7:0] ctrl_byte_t;
endpackage : camera_io_pkg

// >>> sync_two_ff.sv
// Two flip-flop synchroniser for external levels
`timescale 1ns/100ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1Reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1Reg <= '0;
      syncOut <= '0;
    end else begin
      stage1Reg <= asyncIn;
      syncOut <= stage1Reg;
    end
  end
endmodule : sync_two_ff

// >>> trigger_output_mux.sv
// Trigger and user output routing
`timescale 1ns/100ps
`include "camera_io_cfg.svh"
module trigger_output_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control byte
  input wire camera_io_pkg::ctrl_byte_t ctrlByte,
  // Synchronised sources
  input wire logic strobeIn,
  input wire logic linkTrig,
  input wire logic connTrig,
  input wire logic overcurrent,
  // Outputs
  output logic sensorTrig,
  output logic userOutPin,
  output logic userOutPinOe,
  output logic greenLamp,
  output logic redOvercurrentLamp
);
  logic connTrigPol;
  logic userOutSignal;
  logic pushPull;

  // Polarity on connector trigger only
  assign connTrigPol = connTrig ^ ctrlByte[`CIO_BIT_TRIG_INV];
  // Strobe or software level
  assign userOutSignal = ctrlByte[`CIO_BIT_SOURCE] ? ctrlByte[`CIO_BIT_LEVEL] : strobeIn;
  assign pushPull = ctrlByte[`CIO_BIT_DRIVE];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sensorTrig <= 1'b0;
    end else begin
      sensorTrig <= ctrlByte[`CIO_BIT_TRIG_SRC] ? connTrigPol : linkTrig;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      userOutPin <= 1'b0;
      userOutPinOe <= 1'b0;
    end else begin
      userOutPin <= pushPull & userOutSignal;
      userOutPinOe <= pushPull | ~userOutSignal;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      greenLamp <= 1'b0;
      redOvercurrentLamp <= 1'b0;
    end else begin
      greenLamp <= ~ctrlByte[`CIO_BIT_SOURCE] & ctrlByte[`CIO_BIT_LEVEL];
      redOvercurrentLamp <= pushPull & overcurrent;
    end
  end
endmodule : trigger_output_mux

// >>> camera_board_io_control.sv
// Camera board control bank reached over I2C, with trigger and output routing
`timescale 1ns/100ps
`include "camera_io_cfg.svh"
module camera_board_io_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // I2C slave pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Link pins
  input wire logic strobeLinkIn,
  input wire logic linkBoardTrigIn,
  output logic sensorTrigOut,
  // Sensor control
  output logic sensorPowerEn,
  output logic sensorResetB,
  input wire logic sensorClkSrc,
  output logic sensorClk,
  // Connector and lamps
  input wire logic connTrigIn,
  input wire logic overcurrentIn,
  output logic userOutPin,
  output logic userOutPinOe,
  output logic greenLamp,
  output logic redOvercurrentLamp,
  // Status
  output camera_io_pkg::ctrl_byte_t ctrlByte
);
  logic sclS;
  logic sdaS;
  logic strobeS;
  logic linkTrigS;
  logic connTrigS;
  logic ocS;
  logic sclPrev;
  logic sdaPrev;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  camera_io_pkg::i2c_state_e state_reg;
  logic [2:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic readMode_reg;
  logic byteFull_reg;
  camera_io_pkg::ctrl_byte_t ctrl_reg;

  sync_two_ff #(.WIDTH(6)) uSync (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn({sclIn, sdaIn, strobeLinkIn, linkBoardTrigIn, connTrigIn, overcurrentIn}),
    .syncOut({sclS, sdaS, strobeS, linkTrigS, connTrigS, ocS})
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclPrev <= 1'b0;
      sdaPrev <= 1'b0;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  assign sclRise = sclS & ~sclPrev;
  assign sclFall = ~sclS & sclPrev;
  assign startCond = sclS & sclPrev & sdaPrev & ~sdaS;
  assign stopCond = sclS & sclPrev & ~sdaPrev & sdaS;

  // Bit counter and shifter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bitCnt_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else if (startCond) begin
      bitCnt_reg <= 3'h0;
    end else if (sclRise && (state_reg == camera_io_pkg::I2C_ADDR ||
                             state_reg == camera_io_pkg::I2C_DATA)) begin
      shift_reg <= {shift_reg[6:0], sdaS};
      bitCnt_reg <= bitCnt_reg + 3'h1;
    end else if (sclFall && state_reg == camera_io_pkg::I2C_READ) begin
      bitCnt_reg <= bitCnt_reg + 3'h1;
    end else if (sclFall && state_reg == camera_io_pkg::I2C_ADDR_ACK) begin
      bitCnt_reg <= 3'h0;
    end
  end

  // Marks a complete byte until the clock falls, so the fall right after START is not a byte end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      byteFull_reg <= 1'b0;
    end else if (startCond) begin
      byteFull_reg <= 1'b0;
    end else if (sclRise && bitCnt_reg == 3'h7 && (state_reg == camera_io_pkg::I2C_ADDR ||
                                                   state_reg == camera_io_pkg::I2C_DATA)) begin
      byteFull_reg <= 1'b1;
    end else if (sclFall) begin
      byteFull_reg <= 1'b0;
    end
  end

  // Protocol sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= camera_io_pkg::I2C_IDLE;
      readMode_reg <= 1'b0;
    end else if (startCond) begin
      state_reg <= camera_io_pkg::I2C_ADDR;
    end else if (stopCond) begin
      state_reg <= camera_io_pkg::I2C_IDLE;
    end else begin
      unique case (state_reg)
        camera_io_pkg::I2C_IDLE: begin
          state_reg <= camera_io_pkg::I2C_IDLE;
        end
        camera_io_pkg::I2C_ADDR: begin
          if (sclFall && byteFull_reg) begin
            if (shift_reg[7:1] == `CIO_I2C_ADDR) begin
              state_reg <= camera_io_pkg::I2C_ADDR_ACK;
              readMode_reg <= shift_reg[0];
            end else begin
              state_reg <= camera_io_pkg::I2C_SKIP;
            end
          end
        end
        camera_io_pkg::I2C_ADDR_ACK: begin
          if (sclFall) begin
            state_reg <= readMode_reg ? camera_io_pkg::I2C_READ : camera_io_pkg::I2C_DATA;
          end
        end
        camera_io_pkg::I2C_DATA: begin
          if (sclFall && byteFull_reg) begin
            state_reg <= camera_io_pkg::I2C_DATA_ACK;
          end
        end
        camera_io_pkg::I2C_DATA_ACK: begin
          if (sclFall) begin
            state_reg <= camera_io_pkg::I2C_DATA;
          end
        end
        camera_io_pkg::I2C_READ: begin
          if (sclFall && bitCnt_reg == 3'h7) begin
            state_reg <= camera_io_pkg::I2C_READ_ACK;
          end
        end
        camera_io_pkg::I2C_READ_ACK: begin
          if (sclRise) begin
            state_reg <= sdaS ? camera_io_pkg::I2C_SKIP : camera_io_pkg::I2C_READ_ACK;
          end else if (sclFall) begin
            state_reg <= camera_io_pkg::I2C_READ;
          end
        end
        camera_io_pkg::I2C_SKIP: begin
          state_reg <= camera_io_pkg::I2C_SKIP;
        end
      endcase
    end
  end

  // Control byte written on each data byte; bit 7 stored and read back, and reaches no output but the ctrlByte status port
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= `CIO_CTRL_RESET;
    end else if (state_reg == camera_io_pkg::I2C_DATA && sclFall && byteFull_reg) begin
      ctrl_reg <= shift_reg;
    end
  end

  // Data line drive: acknowledge and read data
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sdaOe <= 1'b0;
    end else if (state_reg == camera_io_pkg::I2C_ADDR_ACK ||
                 state_reg == camera_io_pkg::I2C_DATA_ACK) begin
      sdaOe <= 1'b1;
    end else if (state_reg == camera_io_pkg::I2C_READ) begin
      sdaOe <= ~ctrl_reg[3'h7 - bitCnt_reg];
    end else begin
      sdaOe <= 1'b0;
    end
  end
  assign sdaOut = 1'b0;

  // Sensor power and reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sensorPowerEn <= 1'b0;
      sensorResetB <= 1'b0;
    end else begin
      sensorPowerEn <= ctrl_reg[`CIO_BIT_POWER];
      sensorResetB <= ctrl_reg[`CIO_BIT_RESET];
    end
  end

  // Sensor clock passes from the serializer clock output
  assign sensorClk = sensorClkSrc;
  assign ctrlByte = ctrl_reg;

  trigger_output_mux uMux (
    .clk(clk),
    .rst_b(rst_b),
    .ctrlByte(ctrl_reg),
    .strobeIn(strobeS),
    .linkTrig(linkTrigS),
    .connTrig(connTrigS),
    .overcurrent(ocS),
    .sensorTrig(sensorTrigOut),
    .userOutPin(userOutPin),
    .userOutPinOe(userOutPinOe),
    .greenLamp(greenLamp),
    .redOvercurrentLamp(redOvercurrentLamp)
  );
endmodule : camera_board_io_control

// >>> camera_io_asserts.sv
// Port checker for the camera board control block
`timescale 1ns/100ps
module camera_io_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic strobeLinkIn, linkBoardTrigIn, connTrigIn, overcurrentIn,
  input wire logic sensorTrigOut, sensorPowerEn, sensorResetB, userOutPin,
  input wire logic userOutPinOe, greenLamp, redOvercurrentLamp,
  input wire camera_io_pkg::ctrl_byte_t ctrlByte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [2:0] up_reg;
  always_ff @(posedge clk) begin
    if (!rst_b)
      up_reg <= 3'h0;
    else if (up_reg != 3'h7)
      up_reg <= up_reg + 3'h1;
  end
  property p_pwr; sensorPowerEn == $past(ctrlByte[0]); endproperty
  a_pwr: assert property (p_pwr) else $error("power");
  property p_rst; sensorResetB == $past(ctrlByte[1]); endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_grn; greenLamp == ($past(ctrlByte[2]) && !$past(ctrlByte[4])); endproperty
  a_grn: assert property (p_grn) else $error("green");
  property p_lvl; $past(ctrlByte[4]) |-> userOutPin == ($past(ctrlByte[3]) & $past(ctrlByte[2]))
    && userOutPinOe == ($past(ctrlByte[3]) | !$past(ctrlByte[2])); endproperty
  a_lvl: assert property (p_lvl) else $error("level");
  property p_stb; up_reg > 3'h4 && !$past(ctrlByte[4]) |->
    userOutPin == ($past(ctrlByte[3]) & $past(strobeLinkIn, 3)); endproperty
  a_stb: assert property (p_stb) else $error("strobe");
  property p_con; up_reg > 3'h4 && $past(ctrlByte[6]) |->
    sensorTrigOut == ($past(connTrigIn, 3) ^ $past(ctrlByte[5])); endproperty
  a_con: assert property (p_con) else $error("conn");
  property p_lnk; up_reg > 3'h4 && !$past(ctrlByte[6]) |->
    sensorTrigOut == $past(linkBoardTrigIn, 3); endproperty
  a_lnk: assert property (p_lnk) else $error("link");
  property p_red; up_reg > 3'h4 |->
    redOvercurrentLamp == ($past(ctrlByte[3]) & $past(overcurrentIn, 3)); endproperty
  a_red: assert property (p_red) else $error("red");
  c_con: cover property ($past(ctrlByte[6]) && sensorTrigOut);
  c_pp: cover property (userOutPin && userOutPinOe);
  c_red: cover property (redOvercurrentLamp);
endmodule : camera_io_asserts
bind camera_board_io_control camera_io_asserts u_chk (.*);

// >>> i2c_host_model.sv
// Host I2C master model for the control bank
`timescale 1ns/100ps
module i2c_host_model (
  // Bus lines
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaLine
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic bit_x(input logic b, output logic s);
    #20 sdaDrv = b;
    #80 scl = 1'b1;
    s = sdaLine;
    #100 scl = 1'b0;
  endtask : bit_x
  // Start, address, one data byte, ack slots, stop
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic ack);
    logic s;
    sdaDrv = 1'b0;
    #100 scl = 1'b0;
    for (int i = 7; i >= 0; i--)
      bit_x(a[i], s);
    bit_x(1'b1, s);
    ack = !s;
    for (int i = 7; i >= 0; i--)
      bit_x(a[0] | d[i], q[i]);
    bit_x(1'b1, s);
    #20 sdaDrv = 1'b0;
    #80 scl = 1'b1;
    #100 sdaDrv = 1'b1;
    #100;
  endtask : frame
endmodule : i2c_host_model

// >>> camera_board_io_control_tb_top.sv
// Testbench for the camera board control block
`timescale 1ns/100ps
module camera_board_io_control_tb_top;
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_b = 1'b0;
  logic strobe = 1'b0;
  logic linkTrig = 1'b0;
  logic conn = 1'b0;
  logic oc = 1'b0;
  logic scl, sdaDrv, sdaOe, sdaOut, trig, pwr, rstB, sClk, pin, pinOe, green, red;
  camera_io_pkg::ctrl_byte_t ctrl;
  int n_fail = 0;
  int tests_run = 0;
  // Pulled-up data wire
  wire logic sdaLine = sdaDrv & !(sdaOe & !sdaOut);
  camera_board_io_control u_dut (.clk(clk), .rst_b(rst_b), .sclIn(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .strobeLinkIn(strobe), .linkBoardTrigIn(linkTrig),
    .sensorTrigOut(trig), .sensorPowerEn(pwr), .sensorResetB(rstB), .sensorClkSrc(linkClk),
    .sensorClk(sClk), .connTrigIn(conn), .overcurrentIn(oc), .userOutPin(pin),
    .userOutPinOe(pinOe), .greenLamp(green), .redOvercurrentLamp(red), .ctrlByte(ctrl));
  i2c_host_model u_host (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));
  initial begin
    forever #2.5 clk = !clk;
  end
  initial begin
    #1.1;
    forever #62.5 linkClk = !linkClk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic t_reset;
    @(negedge clk);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk("ctrl", 8'h00, ctrl);
    chk("outs", 8'h00, {1'b0, pwr, rstB, trig, pin, pinOe, green, red});
    chk("clk", {7'h0, linkClk}, {7'h0, sClk});
    repeat (4) @(negedge clk);
    $display("reset test done");
  endtask : t_reset
  // Write the bank, set the sources, compare the control byte and the seven power, reset, trigger, user pin and lamp outputs
  task automatic apply(input logic [7:0] c, input logic [3:0] ins, input logic [6:0] e);
    logic [7:0] q;
    logic ack;
    u_host.frame(8'h40, c, q, ack);
    {strobe, linkTrig, conn, oc} = ins;
    repeat (6) @(negedge clk);
    chk("ack", 8'h01, {7'h0, ack});
    chk("ctrl", c, ctrl);
    chk("outs", {1'b0, e}, {1'b0, pwr, rstB, trig, pin, pinOe, green, red});
  endtask : apply
  task automatic t_lamps;
    apply(8'h03, 4'h0, 7'h64);
    apply(8'h04, 4'h0, 7'h06);
    apply(8'h14, 4'h0, 7'h00);
    $display("lamp test done");
  endtask : t_lamps
  task automatic t_user;
    apply(8'h1c, 4'h0, 7'h0c);
    apply(8'h18, 4'h0, 7'h04);
    apply(8'h10, 4'h9, 7'h04);
    apply(8'h08, 4'h9, 7'h0d);
    apply(8'h00, 4'h9, 7'h00);
    $display("user output test done");
  endtask : t_user
  task automatic t_trig;
    apply(8'h20, 4'h4, 7'h14);
    apply(8'h60, 4'h0, 7'h14);
    apply(8'h60, 4'h6, 7'h04);
    apply(8'h40, 4'h2, 7'h14);
    apply(8'h40, 4'h4, 7'h04);
    $display("trigger test done");
  endtask : t_trig
  task automatic t_refuse;
    logic [6:0] bad [4] = '{7'h1a, 7'h50, 7'h57, 7'h21};
    logic [7:0] q;
    logic ack;
    foreach (bad[i]) begin
      u_host.frame({bad[i], 1'b0}, 8'h7f, q, ack);
      chk("nack", 8'h00, {7'h0, ack});
      chk("kept", 8'h40, ctrl);
    end
    u_host.frame(8'h41, 8'hff, q, ack);
    chk("rdack", 8'h01, {7'h0, ack});
    chk("rd", 8'h40, q);
    $display("address test done");
  endtask : t_refuse
  initial begin
    #300000;
    n_fail++;
    test_done();
  end
  initial begin
    t_reset();
    t_lamps();
    t_user();
    t_trig();
    t_refuse();
    t_reset();
    test_done();
  end
endmodule : camera_board_io_control_tb_top
